/* File: logic/vut_pkg.sv */
// constants for the backplane utility and buffer control block
// Overview of operation
// - backplane reset resets bus logic, drives local reset
// - software drives system reset output high
// - fail output follows board fail unless inhibited
// - enabled falling edges of fail inputs interrupt
// - system clock driven only as controller
// - two straps select controller on, off, auto
// - control line transceiver direction, high outbound
// - data line transceiver direction, high outbound
// - shared low enable for data/address transceivers
// - address transceiver direction, outbound for master address and outgoing multiplexed data
// - five strobe and answer driver enables
// - interrupter watches and drives acknowledge chain
// - seven request inputs watched, seven outputs driven
// - read slot address and parity straps
// - fail inhibit is a software bit
package vut_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned AW = 4;
    localparam int unsigned DW = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_IRQ = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam int unsigned CTRL_INHIBIT = 0;
    localparam int unsigned CTRL_SF_EN = 1;
    localparam int unsigned CTRL_AC_EN = 2;
    localparam int unsigned CTRL_SRST = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:1] IRQ_RST = 7'h00;
    localparam int unsigned ST_ACTIVE = 0;
    localparam int unsigned ST_MODE = 1;
    localparam int unsigned ST_PAR_OK = 3;
    localparam int unsigned ST_SLOT = 4;
    localparam int unsigned ST_IRQ_SEEN = 9;
    localparam int unsigned ST_SF = 16;
    localparam int unsigned ST_AC = 17;
    localparam logic [4:0] FIRST_SLOT = 5'h01;
    localparam logic [1:0] CAP_WAIT = 2'h3;
    localparam int unsigned SYSCLK_HZ = 5_000_000;
    localparam int unsigned SYSCLK_HALF = CLK_HZ / (2 * SYSCLK_HZ);
    typedef enum logic [1:0]
    {
        MODE_AUTO = 2'b00,
        MODE_ON = 2'b01,
        MODE_OFF = 2'b10
    } vut_mode_t;
endpackage : vut_pkg

/* File: logic/vut_evt_if.sv */
// event path between the top and the fail monitor
interface vut_evt_if;
    logic sys_fail_n;
    logic ac_fail_n;
    logic sf_en;
    logic ac_en;
    logic bus_rst;
    logic sf_irq;
    logic ac_irq;
    modport top (output sys_fail_n, output ac_fail_n, output sf_en, output ac_en,
        output bus_rst, input sf_irq, input ac_irq);
    modport mon (input sys_fail_n, input ac_fail_n, input sf_en, input ac_en,
        input bus_rst, output sf_irq, output ac_irq);
endinterface : vut_evt_if

/* File: logic/vut_sync.sv */
// two flip-flop synchroniser for a vector of pin levels
module vut_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // pins
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule : vut_sync

/* File: logic/vut_fail_mon.sv */
// falling edge interrupt pulses for system fail and ac fail
module vut_fail_mon (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // event path
    vut_evt_if.mon evt
);
    logic [1:0] prev_q;
    logic [1:0] irq_q;
    logic [1:0] lvl;
    logic [1:0] en;
    logic [1:0] fall;

    assign lvl = {evt.ac_fail_n, evt.sys_fail_n};
    assign en = {evt.ac_en, evt.sf_en};
    assign fall = prev_q & ~lvl & en;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || evt.bus_rst)
        begin
            prev_q <= 2'h3;
            irq_q <= 2'h0;
        end
        else
        begin
            prev_q <= lvl;
            irq_q <= fall;
        end
    end

    assign evt.sf_irq = irq_q[0];
    assign evt.ac_irq = irq_q[1];
endmodule : vut_fail_mon

/* File: logic/vut_util_top.sv */
// backplane utility pins and transceiver control
//
// Local design decisions: the address map and the strobed register port.
module vut_util_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    // reset pins
    input wire logic i_sys_reset_in_n,
    output logic o_sys_reset_drive,
    output logic o_local_reset_out_n,
    // fail pins
    input wire logic i_sys_fail_in_n,
    input wire logic i_ac_fail_in_n,
    input wire logic i_board_fail_n,
    output logic o_sys_fail_drive,
    output logic o_sys_fail_irq,
    output logic o_ac_fail_irq,
    // system controller
    input wire logic i_sysctl_force_on_n,
    input wire logic i_sysctl_force_off_n,
    input wire logic [4:0] i_slot_addr_n,
    input wire logic i_slot_addr_parity_n,
    output logic o_sysctl_active,
    output logic o_sysclk,
    output logic o_sysclk_oe,
    // bus cycle state from the core
    input wire logic i_master_own,
    input wire logic i_master_write,
    input wire logic i_slave_sel,
    input wire logic i_slave_read,
    input wire logic i_mblt_data,
    input wire logic i_as_drive,
    input wire logic i_ds_drive,
    input wire logic i_ack_drive,
    input wire logic i_buserr_drive,
    input wire logic i_retry_drive,
    // transceiver control
    output logic o_ctrl_lines_dir_out,
    output logic o_data_lines_dir_out,
    output logic o_addr_lines_dir_out,
    output logic o_addr_data_xcvr_oe_n,
    output logic o_addr_strobe_drv_en,
    output logic o_data_strobe_drv_en,
    output logic o_ack_drv_en,
    output logic o_buserr_drv_en,
    output logic o_retry_drv_en,
    // interrupt pins
    input wire logic i_int_ack_chain_in_n,
    input wire logic i_iack_claim,
    output logic o_int_ack_chain_out_n,
    input wire logic [7:1] i_irq_in_n,
    output logic [7:1] o_irq_drive,
    output logic [7:1] o_irq_seen
);
    logic [3:0] ctrl_q;
    logic [7:1] irq_q;
    logic [31:0] rdata_q;
    logic srst_q;
    logic lrst_n_q;
    logic sf_drv_q;
    logic active_q;
    logic sysclk_q;
    logic sysclk_oe_q;
    logic [3:0] xdir_q;
    logic [4:0] drv_q;
    logic iack_out_n_q;
    logic [7:1] irq_drv_q;
    logic [7:1] irq_seen_q;
    logic [1:0] cap_q;
    logic [4:0] slot_q;
    logic par_ok_q;
    logic [1:0] mode_q;
    logic [7:0] div_q;
    logic [11:0] pins_s;
    logic [7:1] irq_s;
    logic [4:0] slot_s;
    logic par_s;
    logic srst_in_n_s;
    logic sf_in_n_s;
    logic ac_in_n_s;
    logic bdf_n_s;
    logic en_n_s;
    logic dis_n_s;
    logic iack_in_n_s;
    logic bus_rst;
    logic cap_done;
    logic [4:0] slot_num;
    logic par_ok;
    logic [1:0] mode_dec;
    logic auto_on;
    logic active_d;
    logic div_end;
    logic wr_ctrl;
    logic wr_irq;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;
    logic dir_ctrl;
    logic dir_data;
    logic dir_addr;
    logic xcvr_on;
    logic [4:0] drv_req;

    vut_evt_if evt ();

    // pin synchronisers
    vut_sync #(
        .W(12),
        .INIT(12'hfff)
    ) u_sync_pins (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_slot_addr_parity_n, i_slot_addr_n, i_int_ack_chain_in_n,
            i_sysctl_force_off_n, i_sysctl_force_on_n, i_board_fail_n,
            i_ac_fail_in_n, i_sys_fail_in_n}),
        .o_q(pins_s)
    );

    vut_sync #(
        .W(8),
        .INIT(8'hff)
    ) u_sync_misc (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_sys_reset_in_n, i_irq_in_n}),
        .o_q({srst_in_n_s, irq_s})
    );

    assign sf_in_n_s = pins_s[0];
    assign ac_in_n_s = pins_s[1];
    assign bdf_n_s = pins_s[2];
    assign en_n_s = pins_s[3];
    assign dis_n_s = pins_s[4];
    assign iack_in_n_s = pins_s[5];
    assign slot_s = pins_s[10:6];
    assign par_s = pins_s[11];

    // backplane reset holds bus side logic
    assign bus_rst = ~srst_in_n_s;

    // fail edge monitor
    assign evt.sys_fail_n = sf_in_n_s;
    assign evt.ac_fail_n = ac_in_n_s;
    assign evt.sf_en = ctrl_q[vut_pkg::CTRL_SF_EN];
    assign evt.ac_en = ctrl_q[vut_pkg::CTRL_AC_EN];
    assign evt.bus_rst = bus_rst;

    vut_fail_mon u_fail_mon (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .evt(evt.mon)
    );

    // strap capture after release
    assign cap_done = (cap_q == vut_pkg::CAP_WAIT);
    assign slot_num = ~slot_s;
    assign par_ok = ^{slot_num, ~par_s};
    assign mode_dec = (!en_n_s && dis_n_s) ? vut_pkg::MODE_ON
        : (en_n_s && !dis_n_s) ? vut_pkg::MODE_OFF
        : vut_pkg::MODE_AUTO;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            cap_q <= 2'h0;
            slot_q <= 5'h00;
            par_ok_q <= 1'b0;
            mode_q <= vut_pkg::MODE_OFF;
        end
        else if (!cap_done)
        begin
            cap_q <= cap_q + 2'h1;
            slot_q <= slot_num;
            par_ok_q <= par_ok;
            mode_q <= mode_dec;
        end
    end

    // controller decision
    assign auto_on = par_ok_q && (slot_q == vut_pkg::FIRST_SLOT);
    assign active_d = cap_done && ((mode_q == vut_pkg::MODE_ON)
        || ((mode_q == vut_pkg::MODE_AUTO) && auto_on));

    // system clock divider
    assign div_end = (div_q == 8'(vut_pkg::SYSCLK_HALF - 1));

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || !active_q)
        begin
            div_q <= 8'h00;
            sysclk_q <= 1'b0;
        end
        else if (div_end)
        begin
            div_q <= 8'h00;
            sysclk_q <= ~sysclk_q;
        end
        else
        begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            active_q <= 1'b0;
            sysclk_oe_q <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            sysclk_oe_q <= active_d;
        end
    end

    // register writes
    assign wr_ctrl = i_we && (i_addr == vut_pkg::OFS_CTRL);
    assign wr_irq = i_we && (i_addr == vut_pkg::OFS_IRQ);

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            ctrl_q <= vut_pkg::CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || bus_rst)
        begin
            irq_q <= vut_pkg::IRQ_RST;
        end
        else if (wr_irq)
        begin
            irq_q <= i_wdata[7:1];
        end
    end

    // register reads
    assign stat_word = {14'h0000,
        ~ac_in_n_s,
        ~sf_in_n_s,
        irq_seen_q,
        slot_q,
        par_ok_q,
        mode_q,
        active_q};
    assign rd_mux = (i_addr == vut_pkg::OFS_CTRL) ? {28'h0000000, ctrl_q}
        : (i_addr == vut_pkg::OFS_IRQ) ? {24'h000000, irq_q, 1'b0}
        : (i_addr == vut_pkg::OFS_STAT) ? stat_word
        : 32'h00000000;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdata_q <= i_re ? rd_mux : 32'h00000000;
        end
    end

    // reset and fail outputs
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            srst_q <= 1'b0;
            lrst_n_q <= 1'b0;
            sf_drv_q <= 1'b0;
        end
        else
        begin
            srst_q <= ctrl_q[vut_pkg::CTRL_SRST];
            lrst_n_q <= ~bus_rst;
            sf_drv_q <= ~bdf_n_s && !ctrl_q[vut_pkg::CTRL_INHIBIT];
        end
    end

    // transceiver direction and enables
    assign dir_ctrl = i_master_own;
    assign dir_data = (i_master_own && i_master_write)
        || (i_slave_sel && i_slave_read);
    assign dir_addr = (i_master_own && (!i_mblt_data || i_master_write))
        || (i_slave_sel && i_mblt_data && i_slave_read);
    assign xcvr_on = i_master_own || i_slave_sel;
    assign drv_req = {i_retry_drive, i_buserr_drive, i_ack_drive,
        i_ds_drive, i_as_drive};

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || bus_rst)
        begin
            xdir_q <= 4'h8;
            drv_q <= 5'h00;
        end
        else
        begin
            xdir_q <= {~xcvr_on, dir_addr, dir_data, dir_ctrl};
            drv_q <= drv_req;
        end
    end

    // interrupter and handler pins
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || bus_rst)
        begin
            iack_out_n_q <= 1'b1;
            irq_drv_q <= 7'h00;
            irq_seen_q <= 7'h00;
        end
        else
        begin
            iack_out_n_q <= iack_in_n_s || i_iack_claim;
            irq_drv_q <= irq_q;
            irq_seen_q <= ~irq_s;
        end
    end

    // outputs
    assign o_rdata = rdata_q;
    assign o_sys_reset_drive = srst_q;
    assign o_local_reset_out_n = lrst_n_q;
    assign o_sys_fail_drive = sf_drv_q;
    assign o_sys_fail_irq = evt.sf_irq;
    assign o_ac_fail_irq = evt.ac_irq;
    assign o_sysctl_active = active_q;
    assign o_sysclk = sysclk_q;
    assign o_sysclk_oe = sysclk_oe_q;
    assign o_ctrl_lines_dir_out = xdir_q[0];
    assign o_data_lines_dir_out = xdir_q[1];
    assign o_addr_lines_dir_out = xdir_q[2];
    assign o_addr_data_xcvr_oe_n = xdir_q[3];
    assign o_addr_strobe_drv_en = drv_q[0];
    assign o_data_strobe_drv_en = drv_q[1];
    assign o_ack_drv_en = drv_q[2];
    assign o_buserr_drv_en = drv_q[3];
    assign o_retry_drv_en = drv_q[4];
    assign o_int_ack_chain_out_n = iack_out_n_q;
    assign o_irq_drive = irq_drv_q;
    assign o_irq_seen = irq_seen_q;
endmodule : vut_util_top

/* File: tb/vut_util_monitor.sv */
// checker for the backplane utility block
module vut_util_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // watched inputs
    input wire logic i_sys_reset_in_n,
    input wire logic i_sys_fail_in_n,
    input wire logic i_board_fail_n,
    input wire logic i_sysctl_force_on_n,
    input wire logic i_sysctl_force_off_n,
    input wire logic i_int_ack_chain_in_n,
    input wire logic i_iack_claim,
    input wire logic i_as_drive,
    input wire logic i_ds_drive,
    input wire logic i_ack_drive,
    input wire logic i_buserr_drive,
    input wire logic i_retry_drive,
    // watched outputs
    input wire logic o_local_reset_out_n,
    input wire logic o_sys_fail_drive,
    input wire logic o_sys_fail_irq,
    input wire logic o_sysctl_active,
    input wire logic o_sysclk,
    input wire logic o_sysclk_oe,
    input wire logic o_int_ack_chain_out_n,
    input wire logic o_addr_strobe_drv_en,
    input wire logic o_data_strobe_drv_en,
    input wire logic o_ack_drv_en,
    input wire logic o_buserr_drv_en,
    input wire logic o_retry_drv_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    property p_lrst; (!i_sys_reset_in_n)[*3] |=> !o_local_reset_out_n; endproperty
    a_lrst: assert property (p_lrst) else $error("local reset missing");
    property p_fail; o_sys_fail_drive |-> !$past(i_board_fail_n, 3); endproperty
    a_fail: assert property (p_fail) else $error("fail drive without cause");
    property p_sfirq; o_sys_fail_irq |-> !$past(i_sys_fail_in_n, 3) ##1 !o_sys_fail_irq;
    endproperty
    a_sfirq: assert property (p_sfirq) else $error("fail pulse wrong");
    property p_clkoe; o_sysclk |-> o_sysclk_oe; endproperty
    a_clkoe: assert property (p_clkoe) else $error("clock while off");
    property p_clkrun; o_sysclk_oe[*3] |-> o_sysclk != $past(o_sysclk); endproperty
    a_clkrun: assert property (p_clkrun) else $error("clock stuck");
    property p_sysctl_active;
        (o_sysclk_oe == o_sysctl_active)
            && (!o_sysctl_active || !i_sysctl_force_on_n || i_sysctl_force_off_n);
    endproperty
    a_sysctl_active: assert property (p_sysctl_active) else $error("controller enable split");
    property p_iack;
        !o_int_ack_chain_out_n |-> !$past(i_int_ack_chain_in_n, 3) && !$past(i_iack_claim);
    endproperty
    a_iack: assert property (p_iack) else $error("ack passed wrongly");
    property p_drv;
        ({o_addr_strobe_drv_en, o_data_strobe_drv_en, o_ack_drv_en, o_buserr_drv_en,
            o_retry_drv_en} & ~$past({i_as_drive, i_ds_drive, i_ack_drive, i_buserr_drive,
            i_retry_drive})) == 5'h00;
    endproperty
    a_drv: assert property (p_drv) else $error("driver enable without request");
    c_sfirq: cover property (o_sys_fail_irq);
    c_sysctl_active: cover property (o_sysctl_active);
    c_lrst: cover property (!o_local_reset_out_n ##1 o_local_reset_out_n);
endmodule : vut_util_monitor

bind vut_util_top vut_util_monitor vut_util_monitor_inst (.*);

/* File: tb/vut_bp_model.sv */
// backplane far side: wired lines and straps
module vut_bp_model (
    // from the block
    input wire logic i_rst_drv,
    input wire logic i_fail_drv,
    input wire logic [7:1] i_irq_drv,
    input wire logic i_local_rst_n,
    // backplane levels
    output logic o_rst_n,
    output logic o_fail_n,
    output logic o_ac_n,
    output logic o_iack_n,
    output logic [7:1] o_irq_n,
    output logic [4:0] o_slot_n,
    output logic o_par_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic other_fail = 1'b0;
    logic ac = 1'b0;
    logic iack = 1'b0;
    logic [7:1] other_irq = 7'h00;
    logic [4:0] slot = 5'h01;
    logic board_rst_n;
    // open collector lines with pull-ups
    assign o_rst_n = ~i_rst_drv;
    assign o_fail_n = ~(i_fail_drv | other_fail);
    assign o_ac_n = ~ac;
    assign o_iack_n = ~iack;
    assign o_irq_n = ~(i_irq_drv | other_irq);
    // strapped slot, odd parity
    assign o_slot_n = ~slot;
    assign o_par_n = ^slot;
    // board reset merge
    assign board_rst_n = i_local_rst_n & o_rst_n;
endmodule : vut_bp_model

/* File: tb/tb_top.sv */
// self-checking bench for the backplane utility block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk, i_rstn, i_we, i_re, i_iack_claim, i_board_fail_n;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic i_sys_reset_in_n, i_sys_fail_in_n, i_ac_fail_in_n, i_int_ack_chain_in_n;
    logic i_sysctl_force_on_n, i_sysctl_force_off_n, i_slot_addr_parity_n;
    logic [4:0] i_slot_addr_n;
    logic [7:1] i_irq_in_n, o_irq_drive, o_irq_seen;
    logic i_master_own, i_master_write, i_slave_sel, i_slave_read, i_mblt_data;
    logic i_as_drive, i_ds_drive, i_ack_drive, i_buserr_drive, i_retry_drive;
    logic o_sys_reset_drive, o_local_reset_out_n, o_sys_fail_drive, o_sys_fail_irq;
    logic o_ac_fail_irq, o_sysctl_active, o_sysclk, o_sysclk_oe, o_int_ack_chain_out_n;
    logic o_ctrl_lines_dir_out, o_data_lines_dir_out, o_addr_lines_dir_out;
    logic o_addr_data_xcvr_oe_n, o_addr_strobe_drv_en, o_data_strobe_drv_en;
    logic o_ack_drv_en, o_buserr_drv_en, o_retry_drv_en;
    wire logic [4:0] en = {o_addr_strobe_drv_en, o_data_strobe_drv_en, o_ack_drv_en,
        o_buserr_drv_en, o_retry_drv_en};
    wire logic [3:0] dir = {o_ctrl_lines_dir_out, o_data_lines_dir_out, o_addr_lines_dir_out,
        o_addr_data_xcvr_oe_n};
    int fail_count = 0;
    int comparisons = 0;
    vut_util_top vut_util_top_inst (.*);
    vut_bp_model vut_bp_model_inst (
        .i_rst_drv(o_sys_reset_drive),
        .i_fail_drv(o_sys_fail_drive),
        .i_irq_drv(o_irq_drive),
        .i_local_rst_n(o_local_reset_out_n),
        .o_rst_n(i_sys_reset_in_n),
        .o_fail_n(i_sys_fail_in_n),
        .o_ac_n(i_ac_fail_in_n),
        .o_iack_n(i_int_ack_chain_in_n),
        .o_irq_n(i_irq_in_n),
        .o_slot_n(i_slot_addr_n),
        .o_par_n(i_slot_addr_parity_n)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic chk(input logic c, input string m);
        comparisons++;
        if (c !== 1'b1)
        begin
            fail_count++;
            $display("Error at %0t ns: %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge i_clk);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1;
        chk((o_rdata & m) === e, "read data");
    endtask : rd
    task automatic core(input logic [4:0] st, input logic [4:0] dr);
        @(posedge i_clk);
        {i_master_own, i_master_write, i_slave_sel, i_slave_read, i_mblt_data} <= st;
        {i_as_drive, i_ds_drive, i_ack_drive, i_buserr_drive, i_retry_drive} <= dr;
        tick(2);
    endtask : core
    task automatic cnt(input int n, output int s, output int a);
        s = 0;
        a = 0;
        repeat (n)
        begin
            tick(1);
            s += int'(o_sys_fail_irq === 1'b1);
            a += int'(o_ac_fail_irq === 1'b1);
        end
    endtask : cnt
    // straps, reset, then controller mode and status
    task automatic t_modes();
        logic [9:0] mt [5] = '{10'h20a, 10'h310, 10'h30c, 10'h115, 10'h00c};
        logic [9:0] t;
        logic c;
        for (int i = 0; i < 5; i++)
        begin
            t = mt[i];
            @(posedge i_clk);
            i_rstn <= 1'b0;
            {i_sysctl_force_on_n, i_sysctl_force_off_n} <= t[9:8];
            vut_bp_model_inst.slot <= t[7:3];
            repeat (10) @(posedge i_clk);
            i_rstn <= 1'b1;
            tick(8);
            chk(o_sysctl_active === t[2], "controller active");
            rd(vut_pkg::OFS_STAT, 32'h1ff, {23'h0, t[7:3], 1'b1, t[1:0], t[2]});
            c = o_sysclk;
            tick(1);
            chk(o_sysclk === (t[2] & ~c) && o_sysclk_oe === t[2], "system clock");
        end
    endtask : t_modes
    // transceiver directions, shared enable, driver enables
    task automatic t_xcvr();
        logic [8:0] ct [6] = '{9'h18e, 9'h10a, 9'h118, 9'h064, 9'h076, 9'h040};
        logic [4:0] dr;
        for (int i = 0; i < 6; i++)
        begin
            dr = (i < 5) ? (5'h10 >> i) : 5'h1f;
            core(ct[i][8:4], dr);
            chk(dir === ct[i][3:0], "direction");
            chk(en === dr, "driver enable");
        end
        core(5'h00, 5'h00);
        chk(o_addr_data_xcvr_oe_n === 1'b1 && en === 5'h00, "idle");
    endtask : t_xcvr
    // board fail, inhibit, fail edge interrupts
    task automatic t_fail();
        int s, a;
        @(posedge i_clk);
        i_board_fail_n <= 1'b0;
        tick(4);
        chk(o_sys_fail_drive === 1'b1, "fail drive");
        rd(vut_pkg::OFS_STAT, 32'h10000, 32'h10000);
        wr(vut_pkg::OFS_CTRL, 32'h1);
        tick(4);
        chk(o_sys_fail_drive === 1'b0, "inhibit");
        @(posedge i_clk);
        i_board_fail_n <= 1'b1;
        vut_bp_model_inst.other_fail <= 1'b1;
        vut_bp_model_inst.ac <= 1'b1;
        cnt(8, s, a);
        chk(s == 0 && a == 0, "pulse while off");
        @(posedge i_clk);
        vut_bp_model_inst.other_fail <= 1'b0;
        vut_bp_model_inst.ac <= 1'b0;
        wr(vut_pkg::OFS_CTRL, 32'h6);
        tick(6);
        @(posedge i_clk);
        vut_bp_model_inst.other_fail <= 1'b1;
        vut_bp_model_inst.ac <= 1'b1;
        cnt(8, s, a);
        chk(s == 1 && a == 1, "one pulse each");
    endtask : t_fail
    // backplane reset out, looped back in
    task automatic t_rst();
        wr(vut_pkg::OFS_CTRL, 32'h8);
        tick(5);
        chk(o_sys_reset_drive === 1'b1, "reset drive");
        chk(o_local_reset_out_n === 1'b0, "local reset");
        chk(vut_bp_model_inst.board_rst_n === 1'b0, "board reset");
        core(5'h10, 5'h1f);
        chk(en === 5'h00, "held in reset");
        rd(vut_pkg::OFS_CTRL, 32'hf, 32'h8);
        wr(vut_pkg::OFS_CTRL, 32'h0);
        tick(5);
        chk(o_local_reset_out_n === 1'b1 && en === 5'h1f, "reset released");
        core(5'h00, 5'h00);
        rd(4'hc, 32'hffffffff, 32'h0);
    endtask : t_rst
    // request levels and acknowledge chain
    task automatic t_int();
        wr(vut_pkg::OFS_IRQ, 32'haa);
        @(posedge i_clk);
        vut_bp_model_inst.other_irq <= 7'h02;
        tick(4);
        chk(o_irq_drive === 7'h55 && o_irq_seen === 7'h57, "requests");
        rd(vut_pkg::OFS_STAT, 32'hfe00, 32'hae00);
        @(posedge i_clk);
        vut_bp_model_inst.iack <= 1'b1;
        tick(4);
        chk(o_int_ack_chain_out_n === 1'b0, "ack passed");
        @(posedge i_clk);
        i_iack_claim <= 1'b1;
        tick(2);
        chk(o_int_ack_chain_out_n === 1'b1, "ack claimed");
    endtask : t_int
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        {i_rstn, i_we, i_re, i_iack_claim, i_addr, i_wdata} = '0;
        {i_board_fail_n, i_sysctl_force_on_n, i_sysctl_force_off_n} = 3'h7;
        {i_master_own, i_master_write, i_slave_sel, i_slave_read, i_mblt_data} = 5'h00;
        {i_as_drive, i_ds_drive, i_ack_drive, i_buserr_drive, i_retry_drive} = 5'h00;
        t_modes();
        t_xcvr();
        t_fail();
        t_rst();
        t_int();
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        end_of_test();
    end
endmodule : tb_top
